//--- rss_pkg.sv
// Purpose: shared constants for the reset source sequencer
// Assumes: 20 MHz logic clock, 8-bit special function register port
// Notes: timing counts derive from times in nanoseconds
package rss_pkg;
    localparam int CLK_HZ = 20000000;
    // power-on release delay in nanoseconds, longest time rounds down
    localparam int PORDLY_NS = 300000;
    localparam int PORDLY_CYC = (PORDLY_NS / 1000) * (CLK_HZ / 1000000);
    // monitor settling time before it may be selected, in nanoseconds
    localparam int MONSETTLE_NS = 100000;
    localparam int MONSETTLE_CYC = (MONSETTLE_NS / 1000) * (CLK_HZ / 1000000);
    localparam logic [7:0] ADDR_SUPPLY_MON = 8'hFF;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'hEF;
    localparam int MON_EN_BIT = 7;
    localparam int MON_STAT_BIT = 6;
    localparam int CAUSE_PIN_BIT = 0;
    localparam int CAUSE_POR_BIT = 1;
    localparam logic [7:0] PORT_LATCH_RESET = 8'hFF;
    localparam logic [15:0] START_ADDR = 16'h0000;
    localparam logic [3:0] WDOG_DIV = 4'hC;
    localparam logic [7:0] RESERVED_READ = 8'h00;
    typedef enum logic [1:0] {RSS_POR, RSS_DELAY, RSS_RUN, RSS_FAIL} rss_state_e;
endpackage : rss_pkg

//--- rss_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: asynchronous active-low reset
// Notes: first stage feeds only the second
module rss_sync
    import rss_pkg::*;
(
    input wire logic clock, // logic clock
    input wire logic nrst, // async reset
    input wire logic rst_val, // reset level
    input wire logic din, // async level
    output logic dout // synced level
);
    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    // next values, stored relative to the reset level
    always_comb begin
        next_stage1 = din ^ rst_val;
        next_stage2 = stage1;
    end

    // register both stages, both clear to the reset level
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    // output restores the true polarity
    assign dout = stage2 ^ rst_val;
endmodule : rss_sync

//--- rss_top.sv
// Purpose: reset source sequencer for a small controller
// Assumes: registers on an 8-bit special function register port
// Notes: one clock, nrst models the supply-good analog release
module rss_top
    import rss_pkg::*;
#(
    parameter int POR_DELAY = PORDLY_CYC, // power-on release count
    parameter int MON_SETTLE = MONSETTLE_CYC // monitor settle count
) (
    input wire logic clock, // 20 MHz clock
    input wire logic nrst, // async power reset
    input wire logic supply_above_raw, // comparator output
    input wire logic pin_reset_n_in, // reset pin level
    input wire logic sfr_wr, // register write strobe
    input wire logic sfr_rd, // register read strobe
    input wire logic [7:0] sfr_addr, // register address
    input wire logic [7:0] sfr_wdata, // write data
    output logic [7:0] sfr_rdata, // read data
    output logic core_reset, // core held in reset
    output logic pin_reset_out, // reset pin drive low
    output logic pin_reset_oe_n, // pin enable, low drives
    output logic [7:0] port_latch, // port output latches
    output logic port_open_drain, // ports open-drain
    output logic weak_pullup_en, // weak pull-ups
    output logic [15:0] pc_start, // fetch start address
    output logic clk_sel_internal, // internal oscillator select
    output logic wdog_enable, // watchdog enabled
    output logic [3:0] wdog_div, // watchdog clock divider
    output logic periph_reset, // registers, timers, interrupts reset
    output logic sp_reset, // stack pointer reinit
    output logic supply_monitor_enable, // monitor enable
    output logic poweron_cause_flag, // power-on cause
    output logic pin_reset_cause_flag, // pin reset cause
    output logic monitor_selected // monitor as reset source
);
    // counter wide enough for the default release count
    localparam int CW = 14;
    localparam logic [CW-1:0] POR_LAST = CW'(POR_DELAY - 1);
    localparam logic [CW-1:0] SET_LAST = CW'(MON_SETTLE - 1);

    // synchronised inputs
    logic supply_ok;
    logic pin_n;

    // sequencer state and counters
    rss_state_e state;
    rss_state_e next_state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [CW-1:0] settle;
    logic [CW-1:0] next_settle;
    logic settled;
    logic next_settled;

    // next values of the registers
    logic next_mon_en;
    logic next_por_flag;
    logic next_pin_flag;
    logic next_mon_sel;
    logic [7:0] next_rdata;
    logic next_core_reset;
    logic next_pin_drive;
    logic [1:0] next_drive_hist;

    // decoded reset causes
    logic sw_por;
    logic mon_trip;
    logic sel_bad;
    logic is_por;
    logic ext_pin_low;
    // own pin drive over the last two cycles
    logic [1:0] drive_hist;

    // decode an address match on a write
    // shared by the cause decode and the register writes
    function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                    input logic [7:0] want);
        wr_hit = wr && (a == want);
    endfunction : wr_hit

    // synchronise comparator and pin before use
    rss_sync u_sync_supply (
        .clock(clock),
        .nrst(nrst),
        .rst_val(1'b0),
        .din(supply_above_raw),
        .dout(supply_ok)
    );
    // pin stage clears high, so leaving reset shows no false pin event
    rss_sync u_sync_pin (
        .clock(clock),
        .nrst(nrst),
        .rst_val(1'b1),
        .din(pin_reset_n_in),
        .dout(pin_n)
    );

    // reset causes seen while running
    always_comb begin
        sw_por = wr_hit(sfr_wr, sfr_addr, ADDR_RESET_CAUSE)
                 && sfr_wdata[CAUSE_PIN_BIT];
        // a select write before the monitor has settled is treated as unsafe and forces a reset
        sel_bad = wr_hit(sfr_wr, sfr_addr, ADDR_RESET_CAUSE)
                  && sfr_wdata[CAUSE_POR_BIT]
                  && !(supply_monitor_enable && settled);
        mon_trip = supply_monitor_enable && monitor_selected && !supply_ok;
        // the pin echoes our own drive back through the synchroniser; ignore it
        ext_pin_low = !pin_n && pin_reset_oe_n && !(|drive_hist);
    end

    // sequencer state and delay counter
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        is_por = 1'b0;
        case (state)
            // delay and power-on states both count as power-on reset
            RSS_POR: begin
                is_por = 1'b1;
                next_cnt = '0;
                if (supply_ok) begin
                    next_state = RSS_DELAY;
                end
            end
            RSS_DELAY: begin
                is_por = 1'b1;
                // a supply drop during the delay restarts the power-on wait
                if (!supply_ok) begin
                    next_state = RSS_POR;
                end else if (cnt == POR_LAST) begin
                    next_state = RSS_RUN;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            RSS_RUN: begin
                // a software power-on request outranks a monitor trip
                if (sw_por) begin
                    next_state = RSS_POR;
                end else if (mon_trip || sel_bad) begin
                    next_state = RSS_FAIL;
                end
            end
            RSS_FAIL: begin
                // release follows the supply back above threshold
                if (supply_ok) begin
                    next_state = RSS_RUN;
                end
            end
            default: next_state = RSS_POR;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= RSS_POR;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // monitor settling timer
    always_comb begin
        next_settle = settle;
        next_settled = settled;
        // disabling the monitor forgets any settling already done
        if (!supply_monitor_enable) begin
            next_settle = '0;
            next_settled = 1'b0;
        // settled stays set until the monitor is switched off
        end else if (!settled) begin
            if (settle == SET_LAST) begin
                next_settled = 1'b1;
            end else begin
                next_settle = settle + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            settle <= '0;
            settled <= 1'b0;
        end else begin
            settle <= next_settle;
            settled <= next_settled;
        end
    end

    // control register, cause flags, read data
    always_comb begin
        next_mon_en = supply_monitor_enable;
        next_por_flag = poweron_cause_flag;
        next_pin_flag = pin_reset_cause_flag;
        next_mon_sel = monitor_selected;
        if (is_por) begin
            next_mon_en = 1'b1;
            next_por_flag = 1'b1;
            next_pin_flag = 1'b0;
            next_mon_sel = 1'b0;
        end else if (state == RSS_FAIL) begin
            next_por_flag = 1'b0;
        end else if (state == RSS_RUN) begin
            // pin reset holds the core but leaves the pin undriven
            if (ext_pin_low) begin
                next_pin_flag = 1'b1;
                next_por_flag = 1'b0;
            end
            // writes only land while running; reset states refuse them
            if (wr_hit(sfr_wr, sfr_addr, ADDR_SUPPLY_MON)) begin
                next_mon_en = sfr_wdata[MON_EN_BIT];
            end
            if (wr_hit(sfr_wr, sfr_addr, ADDR_RESET_CAUSE)) begin
                next_mon_sel = sfr_wdata[CAUSE_POR_BIT];
            end
        end
        // read data holds between reads
        next_rdata = sfr_rdata;
        if (sfr_rd) begin
            case (sfr_addr)
                ADDR_SUPPLY_MON: begin
                    next_rdata = RESERVED_READ;
                    next_rdata[MON_EN_BIT] = supply_monitor_enable;
                    next_rdata[MON_STAT_BIT] = supply_ok;
                end
                ADDR_RESET_CAUSE: begin
                    next_rdata = RESERVED_READ;
                    next_rdata[CAUSE_PIN_BIT] = pin_reset_cause_flag;
                    next_rdata[CAUSE_POR_BIT] = poweron_cause_flag;
                end
                default: next_rdata = RESERVED_READ;
            endcase
        end
        next_core_reset = (next_state != RSS_RUN) || ext_pin_low;
        next_pin_drive = (next_state != RSS_RUN);
        next_drive_hist = {drive_hist[0], !pin_reset_oe_n};
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            supply_monitor_enable <= 1'b1;
            poweron_cause_flag <= 1'b1;
            pin_reset_cause_flag <= 1'b0;
            monitor_selected <= 1'b0;
            sfr_rdata <= RESERVED_READ;
            core_reset <= 1'b1;
            pin_reset_out <= 1'b0;
            pin_reset_oe_n <= 1'b0;
            drive_hist <= 2'h3;
        end else begin
            supply_monitor_enable <= next_mon_en;
            poweron_cause_flag <= next_por_flag;
            pin_reset_cause_flag <= next_pin_flag;
            monitor_selected <= next_mon_sel;
            sfr_rdata <= next_rdata;
            core_reset <= next_core_reset;
            // the pin is only ever pulled low, never driven high
            pin_reset_out <= 1'b0;
            pin_reset_oe_n <= !next_pin_drive;
            drive_hist <= next_drive_hist;
        end
    end

    // reset-time defaults handed to core and ports
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            port_latch <= PORT_LATCH_RESET;
            port_open_drain <= 1'b1;
            weak_pullup_en <= 1'b1;
            pc_start <= START_ADDR;
            clk_sel_internal <= 1'b1;
            wdog_enable <= 1'b1;
            wdog_div <= WDOG_DIV;
            periph_reset <= 1'b1;
            sp_reset <= 1'b1;
        end else begin
            port_latch <= PORT_LATCH_RESET;
            // port mode follows the core reset level
            port_open_drain <= next_core_reset;
            weak_pullup_en <= 1'b1;
            pc_start <= START_ADDR;
            clk_sel_internal <= 1'b1;
            wdog_enable <= 1'b1;
            wdog_div <= WDOG_DIV;
            periph_reset <= next_core_reset;
            sp_reset <= next_core_reset;
        end
    end
endmodule : rss_top

//--- rss_asserts.sv
// Purpose: port checks for the reset source sequencer
// Assumes: one clock, nrst async active low
// Notes: bound from the bench top
module rss_asserts
    import rss_pkg::*;
#(
    parameter int POR_DELAY = 8, // release count
    parameter int MON_SETTLE = 4 // settle count
) (
    input wire logic clock, // clock
    input wire logic nrst, // reset
    input wire logic supply_above_raw, // comparator
    input wire logic pin_reset_n_in, // pin level
    input wire logic sfr_wr, // write strobe
    input wire logic [7:0] sfr_addr, // address
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic core_reset, // core held
    input wire logic pin_reset_out, // pin level out
    input wire logic pin_reset_oe_n, // pin drive
    input wire logic [7:0] port_latch, // latches
    input wire logic port_open_drain, // open-drain
    input wire logic weak_pullup_en, // pull-ups
    input wire logic sp_reset, // stack reinit
    input wire logic [15:0] pc_start, // start address
    input wire logic clk_sel_internal, // osc select
    input wire logic wdog_enable, // watchdog on
    input wire logic [3:0] wdog_div, // watchdog divider
    input wire logic supply_monitor_enable, // monitor on
    input wire logic monitor_selected // monitor source
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    int rel_cnt;
    int next_rel_cnt;
    // cycles since reset release, saturating
    always_comb next_rel_cnt = (rel_cnt < POR_DELAY) ? rel_cnt + 1 : rel_cnt;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rel_cnt <= 0;
        end else begin
            rel_cnt <= next_rel_cnt;
        end
    end
    AST_PORT_STATE: assert property (
        core_reset |-> port_latch == PORT_LATCH_RESET && port_open_drain && weak_pullup_en
        && sp_reset) else $error("pins not in reset state");
    AST_EXIT_STATE: assert property (
        $fell(core_reset) |-> pc_start == START_ADDR && clk_sel_internal && wdog_enable
        && wdog_div == WDOG_DIV) else $error("wrong state on exit");
    AST_POR_HOLD: assert property (
        rel_cnt < POR_DELAY |-> core_reset && !pin_reset_oe_n) else $error("early release");
    AST_PIN_LEVEL: assert property (
        !pin_reset_oe_n |-> !pin_reset_out) else $error("pin driven high");
    AST_SUPPLY_FAIL: assert property (
        !core_reset && supply_monitor_enable && monitor_selected && !supply_above_raw
        |-> ##[1:5] (core_reset && !pin_reset_oe_n)) else $error("no supply reset");
    AST_NO_SELECT: assert property (
        (!core_reset && !monitor_selected && pin_reset_n_in && !sfr_wr) [*4] |=> !core_reset)
        else $error("reset while unselected");
    AST_SELECT_EARLY: assert property (
        !core_reset && sfr_wr && sfr_addr == ADDR_RESET_CAUSE && sfr_wdata[1]
        && !supply_monitor_enable |-> ##[1:4] core_reset) else $error("no reset on select");
    AST_EN_KEPT: assert property (
        $fell(supply_monitor_enable) |-> $past(sfr_wr) && $past(sfr_addr) == ADDR_SUPPLY_MON
        && !$past(sfr_wdata[7])) else $error("monitor enable lost");
endmodule : rss_asserts

//--- rss_partner.sv
// Purpose: supply comparator and reset pin outside the device
// Assumes: pin pulled up, comparator lags one clock
// Notes: bench sets supply state and button
module rss_partner (
    input wire logic clock, // clock
    input wire logic supply_good, // supply above threshold
    input wire logic press, // reset button
    input wire logic drive_n, // device drive, low drives
    input wire logic drive_val, // device drive level
    output logic comp_out, // comparator
    output logic pin_level // resolved pin
);
    logic lag = 1'b1;
    // comparator follows the supply a clock later
    always @(posedge clock) begin
        lag <= supply_good;
    end
    assign comp_out = lag;
    // button or device pulls low, pull-up otherwise
    assign pin_level = press ? 1'b0 : (!drive_n ? drive_val : 1'b1);
endmodule : rss_partner

//--- reset_source_sequencer_tb_top.sv
// Purpose: self-checking bench for the reset source sequencer
// Assumes: 50 ns clock, shortened counts
// Notes: supply and pin come from the partner model
module reset_source_sequencer_tb_top
    import rss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PD = 8;
    localparam int MS = 4;
    logic clock = 1'b0;
    logic nrst, supply_good, press, sfr_wr, sfr_rd, comp, pin_level, core_reset, oe_n;
    logic [7:0] sfr_addr, sfr_wdata, rdata, rv;
    logic [3:0] wdog_div;
    logic clk_int, wd_en, en, por_f, pin_f, pin_out, per_rst;
    int miscompares = 0, checks = 0, cyc = 0, waited;
    // clock and hang guard
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            miscompares++;
            final_report();
        end
    end
    rss_partner u_partner (.clock(clock), .supply_good(supply_good), .press(press),
        .drive_n(oe_n), .drive_val(pin_out), .comp_out(comp), .pin_level(pin_level));
    rss_top #(.POR_DELAY(PD), .MON_SETTLE(MS)) DUT (.clock(clock), .nrst(nrst),
        .supply_above_raw(comp), .pin_reset_n_in(pin_level), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(rdata), .core_reset(core_reset),
        .pin_reset_out(pin_out), .pin_reset_oe_n(oe_n), .port_latch(), .port_open_drain(),
        .weak_pullup_en(), .pc_start(), .clk_sel_internal(clk_int), .wdog_enable(wd_en),
        .wdog_div(wdog_div), .periph_reset(per_rst), .sp_reset(), .supply_monitor_enable(en),
        .poweron_cause_flag(por_f), .pin_reset_cause_flag(pin_f), .monitor_selected());
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clock);
        sfr_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clock);
        sfr_rd <= 1'b0;
        @(negedge clock);
        rv = rdata;
    endtask : rd
    // wait for core reset to reach a level, bounded
    task automatic wait_cr(input logic v, input int n);
        waited = 0;
        while (core_reset !== v && waited < n) begin
            @(negedge clock);
            waited++;
        end
        chk(core_reset, v);
        chk(per_rst, v);
    endtask : wait_cr
    task automatic t_regs();
        rd(ADDR_SUPPLY_MON);
        chk(rv & 8'hC0, 8'hC0);
        wr(ADDR_SUPPLY_MON, 8'h3F);
        rd(ADDR_SUPPLY_MON);
        chk(rv & 8'hC0, 8'h40);
        wr(ADDR_SUPPLY_MON, 8'hBF);
        @(posedge clock) supply_good <= 1'b0;
        repeat (10) @(negedge clock);
        chk(core_reset, 8'h00);
        rd(ADDR_SUPPLY_MON);
        chk(rv & 8'hC0, 8'h80);
        @(posedge clock) supply_good <= 1'b1;
    endtask : t_regs
    task automatic t_monfail();
        repeat (MS + 2) @(posedge clock);
        wr(ADDR_RESET_CAUSE, 8'h02);
        repeat (5) @(negedge clock);
        chk(core_reset, 8'h00);
        @(posedge clock) supply_good <= 1'b0;
        wait_cr(1'b1, 8);
        chk(oe_n, 8'h00);
        @(posedge clock) supply_good <= 1'b1;
        wait_cr(1'b0, 200);
        chk({en, por_f}, 8'h02);
    endtask : t_monfail
    task automatic t_pin();
        @(posedge clock) press <= 1'b1;
        wait_cr(1'b1, 8);
        repeat (3) @(posedge clock);
        press <= 1'b0;
        wait_cr(1'b0, 200);
        chk({pin_f, por_f}, 8'h02);
    endtask : t_pin
    task automatic t_early();
        wr(ADDR_RESET_CAUSE, 8'h00);
        wr(ADDR_SUPPLY_MON, 8'h00);
        wr(ADDR_RESET_CAUSE, 8'h02);
        wait_cr(1'b1, 6);
        wait_cr(1'b0, 200);
        chk({en, por_f}, 8'h00);
        // enabled but not yet settled forces the same reset
        wr(ADDR_SUPPLY_MON, 8'h80);
        wr(ADDR_RESET_CAUSE, 8'h02);
        wait_cr(1'b1, 6);
        wait_cr(1'b0, 200);
        chk({en, por_f}, 8'h02);
    endtask : t_early
    task automatic t_swpor();
        wr(ADDR_RESET_CAUSE, 8'h01);
        wait_cr(1'b1, 6);
        wait_cr(1'b0, 200);
        chk({en, por_f}, 8'h03);
        rd(ADDR_RESET_CAUSE);
        chk(rv & 8'h02, 8'h02);
    endtask : t_swpor
    task automatic final_report();
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    // reset, power-on release, then the scenarios
    initial begin
        {nrst, press, sfr_wr, sfr_rd, supply_good} = 5'h01;
        {sfr_addr, sfr_wdata} = 16'h0000;
        repeat (2) @(posedge clock);
        chk(oe_n, 8'h00);
        chk(pin_out, 8'h00);
        nrst <= 1'b1;
        wait_cr(1'b0, PD + 8);
        chk({7'h00, waited >= PD && waited <= PD + 5}, 8'h01);
        chk({en, por_f, clk_int, wd_en}, 8'h0F);
        chk(wdog_div, WDOG_DIV);
        t_regs();
        t_monfail();
        t_pin();
        t_early();
        t_swpor();
        final_report();
    end
endmodule : reset_source_sequencer_tb_top
bind rss_top rss_asserts #(.POR_DELAY(POR_DELAY), .MON_SETTLE(MON_SETTLE)) u_asserts (
    .clock(clock), .nrst(nrst), .supply_above_raw(supply_above_raw),
    .pin_reset_n_in(pin_reset_n_in), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .core_reset(core_reset), .pin_reset_out(pin_reset_out),
    .pin_reset_oe_n(pin_reset_oe_n), .port_latch(port_latch), .port_open_drain(port_open_drain),
    .weak_pullup_en(weak_pullup_en), .sp_reset(sp_reset), .pc_start(pc_start),
    .clk_sel_internal(clk_sel_internal), .wdog_enable(wdog_enable), .wdog_div(wdog_div),
    .supply_monitor_enable(supply_monitor_enable), .monitor_selected(monitor_selected));
